// ### rtl/spcd_device.sv
// Device end: decodes host command bytes into settings, playback requests and power state
`timescale 1ns/1ns
module spcd_device
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                clk_en,
  // Command link
  spcd_if.dev                      link,
  // Status from the playback engine
  input  wire logic [3:0]          chan_ready_in,
  input  wire logic [3:0]          chan_busy_n_in,
  input  wire logic [7:0]          stored_protect_key,
  input  wire spcd_pkg::spcd_fam_e rate_family,
  input  wire logic [6:0]          channel_volume_target,
  // Settings and requests
  output logic [3:0]               amp_gain_code,
  output logic                     ramp_enable,
  output logic [2:0]               ramp_step_code,
  output logic [6:0]               ramped_volume,
  output logic                     passthrough_active,
  output logic                     watchdog_clear,
  output logic                     osc_stop,
  output logic                     phrase_store,
  output logic                     phrase_start,
  output logic [1:0]               channel_code,
  output logic [9:0]               phrase_index
);
  import spcd_pkg::*;
  logic [3:0] rdy_s1_r, rdy_s2_r, bsy_s1_r, bsy_s2_r;
  logic [7:0] first_r;
  logic       second_r;
  logic [3:0] amp_gain_code_r;
  logic       ramp_enable_r;
  logic [2:0] ramp_step_code_r;
  logic       pass_r, wdt_r, store_r, start_r, pd_wait_r, osc_stop_r;
  logic [1:0] chan_r;
  logic [9:0] phrase_r;
  logic [PD_W-1:0] pd_cnt_r;
  logic [6:0] level;
  logic       take, gated_ok, is_two;
  logic [7:0] b;

  assign link.channel_cmd_ready = rdy_s2_r;
  assign link.channel_busy_n    = bsy_s2_r;
  assign amp_gain_code      = amp_gain_code_r;
  assign ramp_enable        = ramp_enable_r;
  assign ramp_step_code     = ramp_step_code_r;
  assign passthrough_active = pass_r;
  assign watchdog_clear     = wdt_r;
  assign osc_stop           = osc_stop_r;
  assign phrase_store       = store_r;
  assign phrase_start       = start_r;
  assign channel_code       = chan_r;
  assign phrase_index       = phrase_r;
  assign b = link.byte_data;
  // Pass-through swallows all traffic; nothing is decoded once entered
  assign take = clk_en && link.byte_valid && !pass_r && !pd_wait_r;
  assign is_two = (b == OP_GAIN) || (b == OP_RAMP) || (b == OP_PASS) ||
                  (b[7:4] == NIB_SELECT) || (b[7:4] == NIB_PHRASE_CMD_A);
  assign gated_ok = rdy_s2_r[first_r[1:0]];

  // Status from engine crosses no domain, but bench drives it freely
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdy_s1_r <= '0;
      rdy_s2_r <= '0;
    end else if (clk_en) begin
      rdy_s1_r <= chan_ready_in;
      rdy_s2_r <= rdy_s1_r;
    end
  end

  // Busy starts idle so a power-down right after reset is not refused
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bsy_s1_r <= '1;
      bsy_s2_r <= '1;
    end else if (clk_en) begin
      bsy_s1_r <= chan_busy_n_in;
      bsy_s2_r <= bsy_s1_r;
    end
  end

  // Byte pairing
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      first_r  <= '0;
      second_r <= 1'b0;
    end else if (take) begin
      if (second_r) begin
        second_r <= 1'b0;
      end else if (is_two) begin
        first_r  <= b;
        second_r <= 1'b1;
      end
    end
  end

  // Gain setting; power-down puts the default back
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      amp_gain_code_r <= GAIN_DEFAULT;
    end else if (clk_en && osc_stop_r) begin
      amp_gain_code_r <= GAIN_DEFAULT;
    end else if (take && second_r && first_r == OP_GAIN) begin
      // Forbidden codes 1 and 2 are dropped rather than stored
      if (b[GAIN_LSB+:4] >= GAIN_MIN_OK || b[GAIN_LSB+:4] == GAIN_MUTE) begin
        amp_gain_code_r <= b[GAIN_LSB+:4];
      end
    end
  end

  // Ramp setting, taken whatever the channel status
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ramp_enable_r    <= 1'b0;
      ramp_step_code_r <= '0;
    end else if (clk_en && osc_stop_r) begin
      ramp_enable_r    <= 1'b0;
      ramp_step_code_r <= '0;
    end else if (take && second_r && first_r == OP_RAMP) begin
      ramp_enable_r    <= b[RAMP_EN_BIT];
      ramp_step_code_r <= b[STEP_LSB+:3];
    end
  end

  // Pass-through entry; only reset leaves it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pass_r <= 1'b0;
    end else if (take && second_r && first_r == OP_PASS && !link.port_is_i2c &&
                 stored_protect_key != KEY_LOCKED && b == stored_protect_key) begin
      pass_r <= 1'b1;
    end
  end

  // Phrase select and phrase_cmd_a
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      store_r  <= 1'b0;
      start_r  <= 1'b0;
      chan_r   <= '0;
      phrase_r <= '0;
    end else if (clk_en) begin
      store_r <= 1'b0;
      start_r <= 1'b0;
      if (take && second_r && gated_ok &&
          (first_r[7:4] == NIB_SELECT || first_r[7:4] == NIB_PHRASE_CMD_A)) begin
        chan_r   <= first_r[1:0];
        phrase_r <= {first_r[3:2], b};
        store_r  <= (first_r[7:4] == NIB_SELECT);
        start_r  <= (first_r[7:4] == NIB_PHRASE_CMD_A);
      end
    end
  end

  // Watchdog clear is a one-cycle pulse to the timer, whatever the channels do
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wdt_r <= 1'b0;
    end else if (clk_en) begin
      wdt_r <= take && !second_r && b == OP_WDT_CLEAR;
    end
  end

  // Power-down waits out the processing time before the oscillator stops
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pd_wait_r  <= 1'b0;
      pd_cnt_r   <= '0;
      osc_stop_r <= 1'b0;
    end else if (clk_en) begin
      if (take && !second_r && b == OP_POWER_DOWN && &bsy_s2_r) begin
        pd_wait_r <= 1'b1;
        pd_cnt_r  <= '0;
      end else if (pd_wait_r) begin
        if (pd_cnt_r == PD_W'(PD_CYCLES - 1)) begin
          pd_wait_r  <= 1'b0;
          osc_stop_r <= 1'b1;
        end else begin
          pd_cnt_r <= pd_cnt_r + 1'b1;
        end
      end else if (take) begin
        osc_stop_r <= 1'b0;
      end
    end
  end

  // One ramp serves the addressed volume; the group period follows the rate family
  spcd_ramp u_ramp (
    .sys_clk        (sys_clk),
    .reset          (reset),
    .clk_en         (clk_en),
    .ramp_en        (ramp_enable_r),
    .ramp_step_code (ramp_step_code_r),
    .grp_len        (grp_cycles(rate_family)),
    .target         (channel_volume_target),
    .level          (level)
  );

  // Registered so the port comes straight from a flop
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ramped_volume <= '0;
    end else if (clk_en) begin
      ramped_volume <= level;
    end
  end
endmodule

// ### common/spcd_pkg.sv
// Package of opcodes, field positions, reset values and timing counts for the command decoder
// Functional notes
// - Gain command anytime; default code means -4dB.
// - Stop keeps gain; power-down restores default.
// - Gain codes 0xF..0x3 map; 1,2 forbidden.
// - Ramp enable is byte-two bit 0, default off.
// - Ramping steps volume one unit once per ramp_periods(code) group periods.
// - Step code halves step from 256 to 2.
// - Ramp time uses ceil(264/(256>>code)) periods.
// - Group period chosen from sampling rate family.
// - Pass-through honoured on clocked serial only.
// - Enter pass-through if key matches, not 0x69.
// - Pass-through lasts until reset pin asserted.
// - Host powers up before pass-through command.
// - Watchdog clear restarts the watchdog counter.
// - Power-down only when no channel busy.
// - Wait processing time, then stop oscillator.
// - Phrase select two bytes, channel must be ready.
// - Channel code 0..3; phrase index 0..1023.
// - Phrase select only records; start plays later.
// - Phrase_cmd_a command 0100 starts phrase directly.
// - Phrases from 1024 need the extended command.
package spcd_pkg;
  localparam logic [7:0] OP_GAIN       = 8'h00;
  localparam logic [7:0] OP_RAMP       = 8'h0c;
  localparam logic [7:0] OP_PASS       = 8'h10;
  localparam logic [7:0] OP_WDT_CLEAR  = 8'h14;
  localparam logic [7:0] OP_POWER_DOWN = 8'h20;
  localparam logic [3:0] NIB_SELECT    = 4'h3;
  localparam logic [3:0] NIB_PHRASE_CMD_A      = 4'h4;
  localparam int         GAIN_LSB      = 2;
  localparam int         RAMP_EN_BIT   = 0;
  localparam int         STEP_LSB      = 1;
  localparam logic [3:0] GAIN_DEFAULT  = 4'h8;
  localparam logic [3:0] GAIN_MUTE     = 4'h0;
  localparam logic [3:0] GAIN_MIN_OK   = 4'h3;
  localparam logic [7:0] KEY_LOCKED    = 8'h69;
  localparam logic [7:0] RAMP_NUM      = 8'hff;
  localparam int         RAMP_MUL      = 264;
  localparam int         RAMP_DIV      = 256;
  localparam int         CLK_MHZ       = 100;
  localparam int         GRP_NS_A      = 23440;
  localparam int         GRP_NS_B      = 39060;
  localparam int         GRP_NS_C      = 31250;
  localparam int         GRP_NS_D      = 22680;
  localparam int         GRP_NS_E      = 20830;
  localparam int         PD_TIME_NS    = 1000;
  localparam int         PD_CYCLES     = (PD_TIME_NS * CLK_MHZ) / 1000;
  localparam int         PD_W          = 16;
  localparam int         GRP_W         = 16;
  typedef enum logic [2:0] {FAM_A, FAM_B, FAM_C, FAM_D, FAM_E} spcd_fam_e;
  // Longest time rounds down to whole cycles
  function automatic logic [GRP_W-1:0] grp_cycles(input spcd_fam_e f);
    int ns;
    case (f)
      FAM_A:   ns = GRP_NS_A;
      FAM_B:   ns = GRP_NS_B;
      FAM_C:   ns = GRP_NS_C;
      FAM_D:   ns = GRP_NS_D;
      default: ns = GRP_NS_E;
    endcase
    grp_cycles = GRP_W'((ns * CLK_MHZ) / 1000);
  endfunction
  // Periods per volume unit: ceil(264 / (256 >> code))
  function automatic logic [7:0] ramp_periods(input logic [2:0] code);
    int d;
    d = RAMP_DIV >> code;
    ramp_periods = 8'((RAMP_MUL + d - 1) / d);
  endfunction
endpackage

// ### common/spcd_if.sv
// Interface carrying command bytes and channel status between host and decoder
`timescale 1ns/1ns
interface spcd_if;
  logic       byte_valid;
  logic [7:0] byte_data;
  logic       port_is_i2c;
  logic [3:0] channel_cmd_ready;
  logic [3:0] channel_busy_n;
  modport dev  (input byte_valid, byte_data, port_is_i2c, output channel_cmd_ready,
                channel_busy_n);
  modport host (output byte_valid, byte_data, port_is_i2c, input channel_cmd_ready,
                channel_busy_n);
endinterface

// ### rtl/spcd_ramp.sv
// Volume ramp for one channel: steps toward target once every ramp_periods(code) group periods
`timescale 1ns/1ns
module spcd_ramp
(
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       reset,
  input  wire logic                       clk_en,
  // Control
  input  wire logic                       ramp_en,
  input  wire logic [2:0]                 ramp_step_code,
  input  wire logic [spcd_pkg::GRP_W-1:0] grp_len,
  input  wire logic [6:0]                 target,
  // Result
  output logic [6:0]                      level
);
  import spcd_pkg::*;
  logic [GRP_W-1:0] tick_r;
  logic [7:0]       sub_r;
  logic [6:0]       level_r;
  assign level = level_r;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tick_r <= '0;
    end else if (clk_en) begin
      tick_r <= (tick_r + 1'b1 >= grp_len) ? '0 : tick_r + 1'b1;
    end
  end
  // Each unit of volume takes ramp_periods(code) group periods
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      level_r <= '0;
      sub_r   <= '0;
    end else if (clk_en) begin
      if (!ramp_en) begin
        level_r <= target;
        sub_r   <= '0;
      end else if (level_r != target && tick_r == '0) begin
        if (sub_r + 1'b1 >= ramp_periods(ramp_step_code)) begin
          sub_r   <= '0;
          level_r <= (level_r < target) ? level_r + 1'b1 : level_r - 1'b1;
        end else begin
          sub_r <= sub_r + 1'b1;
        end
      end
    end
  end
endmodule

// ### rtl/spcd_host.sv
// Host end: turns user requests into one- and two-byte command sequences
`timescale 1ns/1ns
module spcd_host
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // Command link
  spcd_if.host            link,
  // User request
  input  wire logic       req_valid,
  input  wire logic [7:0] req_first,
  input  wire logic [7:0] req_second,
  input  wire logic       req_two,
  input  wire logic       req_use_i2c,
  // Status
  output logic            req_ready,
  output logic            req_refused
);
  import spcd_pkg::*;
  typedef enum logic [1:0] {HS_IDLE, HS_SECOND} spcd_hs_e;
  spcd_hs_e   st_r;
  logic [7:0] sec_r, byte_r;
  logic       val_r, i2c_r, refused_r, bad;
  logic [3:0] rdy_s1_r, rdy_s2_r;

  assign link.byte_valid  = val_r;
  assign link.byte_data   = byte_r;
  assign link.port_is_i2c = i2c_r;
  assign req_ready   = (st_r == HS_IDLE);
  assign req_refused = refused_r;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdy_s1_r <= '0;
      rdy_s2_r <= '0;
    end else if (clk_en) begin
      rdy_s1_r <= link.channel_cmd_ready;
      rdy_s2_r <= rdy_s1_r;
    end
  end

  // Host duties: no forbidden gain codes, no I2C pass-through, phrase only when ready
  always_comb begin
    bad = 1'b0;
    if (req_first == OP_GAIN && (req_second[GAIN_LSB+:4] == 4'h1 ||
        req_second[GAIN_LSB+:4] == 4'h2)) bad = 1'b1;
    if (req_first == OP_PASS && req_use_i2c) bad = 1'b1;
    if ((req_first[7:4] == NIB_SELECT || req_first[7:4] == NIB_PHRASE_CMD_A) &&
        !rdy_s2_r[req_first[1:0]]) bad = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r      <= HS_IDLE;
      sec_r     <= '0;
      byte_r    <= '0;
      val_r     <= 1'b0;
      i2c_r     <= 1'b0;
      refused_r <= 1'b0;
    end else if (clk_en) begin
      val_r     <= 1'b0;
      refused_r <= 1'b0;
      case (st_r)
        HS_IDLE: begin
          if (req_valid && bad) begin
            refused_r <= 1'b1;
          end else if (req_valid) begin
            byte_r <= req_first;
            val_r  <= 1'b1;
            i2c_r  <= req_use_i2c;
            sec_r  <= req_second;
            if (req_two) st_r <= HS_SECOND;
          end
        end
        HS_SECOND: begin
          byte_r <= sec_r;
          val_r  <= 1'b1;
          st_r   <= HS_IDLE;
        end
        default: st_r <= HS_IDLE;
      endcase
    end
  end
endmodule

// ### verif/spcd_link_chk.sv
// Checker of the command link between host and decoder ends
`timescale 1ns/1ns
module spcd_link_chk
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       reset,
  // Link
  input wire logic       byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic       port_is_i2c,
  input wire logic [3:0] channel_cmd_ready,
  input wire logic [3:0] channel_busy_n
);
  import spcd_pkg::*;
  logic       sec_r;
  logic [7:0] op_r;
  logic       two;
  assign two = (byte_data inside {OP_GAIN, OP_RAMP, OP_PASS}) ||
               (byte_data[7:4] inside {NIB_SELECT, NIB_PHRASE_CMD_A});
  // Tracks whether the next byte is the second of a pair
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sec_r <= 1'b0;
    end else if (byte_valid) begin
      sec_r <= !sec_r && two;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (byte_valid && !sec_r) begin
      op_r <= byte_data;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence first_s;
    byte_valid && !sec_r;
  endsequence
  sequence pair_s;
    first_s ##0 two;
  endsequence
  gain_code_legal_a: assert property (byte_valid && sec_r && op_r == OP_GAIN
    |-> !(byte_data[5:2] inside {4'h1, 4'h2})) else $error("forbidden gain code");
  second_follows_a: assert property (pair_s |=> byte_valid)
    else $error("second byte late");
  port_held_a: assert property (pair_s |=> $stable(port_is_i2c))
    else $error("port changed in pair");
  no_i2c_pass_a: assert property (first_s ##0 byte_data == OP_PASS |-> !port_is_i2c)
    else $error("pass-through over i2c");
  select_ready_a: assert property (first_s ##0 byte_data[7:4] == NIB_SELECT
    |-> channel_cmd_ready[byte_data[1:0]]) else $error("select while not ready");
  phrase_cmd_a_ready_a: assert property (first_s ##0 byte_data[7:4] == NIB_PHRASE_CMD_A
    |-> channel_cmd_ready[byte_data[1:0]]) else $error("phrase_cmd_a while not ready");
  reset_idle_a: assert property ($fell(reset) |-> channel_busy_n == 4'hf)
    else $error("busy after reset");
  reset_unready_a: assert property ($fell(reset) |-> channel_cmd_ready == 4'h0)
    else $error("ready during reset");
endmodule

// ### verif/speech_playback_command_decoder_test.sv
// Testbench joining host and decoder ends over the command link
`timescale 1ns/1ns
module speech_playback_command_decoder_test;
  import spcd_pkg::*;
  logic       sys_clk, reset, clk_en, req_valid, req_two, req_use_i2c, req_ready, req_refused;
  logic [7:0] req_first, req_second, key;
  logic [3:0] rdy, bsy_n, gain;
  logic [6:0] vol_tgt, vol;
  logic [2:0] step;
  logic [1:0] chan;
  logic [9:0] idx;
  logic       ramp_on, pass_on, wdc, osc, p_store, p_start;
  logic [3:0] codes [4] = '{4'hf, 4'h9, 4'h3, 4'h0};
  int         errors = 0, checked = 0, n_ref = 0, n_store = 0, n_start = 0, n_wdc = 0;
  int         per;
  spcd_if link ();
  spcd_host u_spcd_host (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .link(link.host),
    .req_valid(req_valid), .req_first(req_first), .req_second(req_second), .req_two(req_two),
    .req_use_i2c(req_use_i2c), .req_ready(req_ready), .req_refused(req_refused));
  spcd_device u_spcd_device (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .link(link.dev), .chan_ready_in(rdy), .chan_busy_n_in(bsy_n), .stored_protect_key(key),
    .rate_family(FAM_E), .channel_volume_target(vol_tgt), .amp_gain_code(gain),
    .ramp_enable(ramp_on), .ramp_step_code(step), .ramped_volume(vol),
    .passthrough_active(pass_on), .watchdog_clear(wdc), .osc_stop(osc),
    .phrase_store(p_store), .phrase_start(p_start), .channel_code(chan), .phrase_index(idx));
  spcd_link_chk u_spcd_link_chk (.sys_clk(sys_clk), .reset(reset),
    .byte_valid(link.byte_valid), .byte_data(link.byte_data), .port_is_i2c(link.port_is_i2c),
    .channel_cmd_ready(link.channel_cmd_ready), .channel_busy_n(link.channel_busy_n));
  always @(negedge sys_clk) begin
    if (req_refused === 1'b1) n_ref++;
    if (p_store === 1'b1) n_store++;
    if (p_start === 1'b1) n_start++;
    if (wdc === 1'b1) n_wdc++;
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Holds the request until the host is ready, then lets the pair land
  task automatic send(logic [7:0] f, logic [7:0] s, logic two, logic i2c);
    int n;
    n = 0;
    @(negedge sys_clk);
    {req_valid, req_first, req_second, req_two, req_use_i2c} = {1'b1, f, s, two, i2c};
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 200) begin
      errors++;
      give_verdict();
    end
    @(negedge sys_clk);
    req_valid = 1'b0;
    repeat (6) @(negedge sys_clk);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {reset, clk_en, req_valid, req_first, req_second, req_two, req_use_i2c} = {2'b11, 19'h0};
    {rdy, bsy_n, key, vol_tgt} = {8'hff, 8'h5a, 7'h5};
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    check("gain", gain, GAIN_DEFAULT);
    check("ramp", {ramp_on, step}, 4'h0);
    check("volume", vol, 7'h5);
    $display("test reset done");
    foreach (codes[i]) begin
      send(OP_GAIN, {2'h0, codes[i], 2'h0}, 1'b1, 1'b0);
      check("gain", gain, codes[i]);
    end
    send(OP_GAIN, 8'h04, 1'b1, 1'b0);
    check("gain", gain, 4'h0);
    check("refusals", n_ref, 1);
    clk_en = 1'b0;
    send(OP_GAIN, 8'h24, 1'b1, 1'b0);
    check("frozen gain", gain, 4'h0);
    clk_en = 1'b1;
    $display("test gain done");
    send(OP_RAMP, 8'h0f, 1'b1, 1'b0);
    check("ramp", {ramp_on, step}, 4'hf);
    send(OP_RAMP, 8'h01, 1'b1, 1'b0);
    check("ramp", {ramp_on, step}, 4'h8);
    // Step code 0 needs ceil(264/256) = 2 group periods per unit
    per = 2 * ((GRP_NS_E * CLK_MHZ) / 1000);
    vol_tgt = 7'h7;
    repeat (per / 2) @(negedge sys_clk);
    check("volume", vol, 7'h5);
    repeat (2 * per + 20) @(negedge sys_clk);
    check("volume", vol, 7'h7);
    $display("test ramp done");
    send(OP_WDT_CLEAR, 8'h00, 1'b0, 1'b0);
    check("clears", n_wdc, 1);
    send({NIB_SELECT, 2'b10, 2'b10}, 8'ha5, 1'b1, 1'b0);
    check("stores", n_store, 1);
    check("starts", n_start, 0);
    check("phrase", {chan, idx}, {2'h2, 10'h2a5});
    for (int c = 0; c < 4; c++) begin
      send({NIB_PHRASE_CMD_A, 2'b11, 2'(c)}, 8'(c * 3), 1'b1, 1'b0);
      check("phrase_cmd_a", {chan, idx}, {2'(c), 2'b11, 8'(c * 3)});
    end
    check("starts", n_start, 4);
    rdy = 4'hd;
    repeat (4) @(negedge sys_clk);
    send({NIB_PHRASE_CMD_A, 4'h1}, 8'h00, 1'b1, 1'b0);
    check("starts", n_start, 4);
    check("refusals", n_ref, 2);
    rdy = 4'hf;
    $display("test phrase done");
    send(OP_GAIN, 8'h3c, 1'b1, 1'b0);
    bsy_n = 4'he;
    repeat (4) @(negedge sys_clk);
    send(OP_POWER_DOWN, 8'h00, 1'b0, 1'b0);
    repeat (110) @(negedge sys_clk);
    check("osc stop", osc, 1'b0);
    bsy_n = 4'hf;
    repeat (4) @(negedge sys_clk);
    send(OP_POWER_DOWN, 8'h00, 1'b0, 1'b0);
    repeat (100) @(negedge sys_clk);
    check("osc stop", osc, 1'b1);
    check("gain", gain, GAIN_DEFAULT);
    check("ramp", ramp_on, 1'b0);
    $display("test power done");
    send(OP_PASS, 8'h5a, 1'b1, 1'b1);
    check("refusals", n_ref, 3);
    send(OP_PASS, 8'h33, 1'b1, 1'b0);
    check("osc stop", osc, 1'b0);
    check("pass", pass_on, 1'b0);
    key = KEY_LOCKED;
    send(OP_PASS, KEY_LOCKED, 1'b1, 1'b0);
    check("pass", pass_on, 1'b0);
    key = 8'h5a;
    send(OP_PASS, 8'h5a, 1'b1, 1'b0);
    check("pass", pass_on, 1'b1);
    send(OP_GAIN, 8'h3c, 1'b1, 1'b0);
    check("pass", {pass_on, gain}, {1'b1, GAIN_DEFAULT});
    reset = 1'b1;
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    check("pass", {pass_on, gain}, {1'b0, GAIN_DEFAULT});
    $display("test pass done");
    give_verdict();
  end
endmodule
